/* File: spdio_pkg.sv */
// spdio_pkg: constants, register map and types of the static port digital io block
// assumes: 100 MHz clk, 8 ports of 8 open-drain channels each
`default_nettype none

package spdio_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // geometry and bus widths
  localparam int PORTS = 8;
  localparam int CHANS = 8;
  localparam int LINES = PORTS * CHANS;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int VSEL_W = 3;
  localparam int SRC_W = 7;

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses, one aligned word per register
  localparam logic [ADDR_W-1:0] CFG_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] DATA_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 8'h40;
  localparam logic [ADDR_W-1:0] PORT_SPAN = 8'h20;

  // config word fields
  localparam int CFG_DIR_BIT = 0;
  localparam int CFG_POL_BIT = 1;
  localparam int CFG_VSEL_LSB = 4;

  // status word fields
  localparam int STAT_REFUSE_BIT = 0;
  localparam int STAT_GATED_BIT = 1;
  localparam int STAT_VOK_LSB = 8;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic DIR_RST = 1'b0;
  localparam logic POL_RST = 1'b0;
  localparam logic [CHANS-1:0] DATA_RST = 8'hff;
  localparam logic [LINES-1:0] LINE_IDLE = {LINES{1'b1}};

  ////////////////////////////////////////////////////////////////////////////
  // direction, polarity and reference choices
  localparam logic DIR_IN = 1'b0;
  localparam logic DIR_OUT = 1'b1;
  localparam logic POL_NORMAL = 1'b0;

  typedef enum logic [VSEL_W-1:0] {
    VSEL_NONE = 3'h0,
    VSEL_3V3 = 3'h1,
    VSEL_5V = 3'h2,
    VSEL_12V = 3'h3,
    VSEL_24V = 3'h4,
    VSEL_EXT = 3'h5,
    VSEL_TTL = 3'h6,
    VSEL_LOW_VOLTAGE_EMULATION = 3'h7
  } spdio_vsel_t;

endpackage : spdio_pkg

`default_nettype wire

/* File: spdio_sync_if.sv */
// spdio_sync_if: raw channel levels in, settled channel levels out
// assumes: one producer of raw levels and one synchroniser
`default_nettype none

interface spdio_sync_if;
  import spdio_pkg::*;

  logic [LINES-1:0] raw;
  logic [LINES-1:0] clean;

  modport src (output raw, input clean);
  modport sink (input raw, output clean);
endinterface : spdio_sync_if

`default_nettype wire

/* File: spdio_sync.sv */
// spdio_sync: three-stage synchroniser with agreement filter for all channel pins
// assumes: pins are asynchronous to clk; idle lines read high
`default_nettype none

module spdio_sync
  import spdio_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels
  spdio_sync_if.sink sif
);

  logic [LINES-1:0] meta_r;
  logic [LINES-1:0] hold_r;
  logic [LINES-1:0] last_r;
  logic [LINES-1:0] clean_r;

  ////////////////////////////////////////////////////////////////////////////
  // three flops; first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= LINE_IDLE;
      hold_r <= LINE_IDLE;
      last_r <= LINE_IDLE;
    end else begin
      meta_r <= sif.raw;
      hold_r <= meta_r;
      last_r <= hold_r;
    end
  end

  // a bit moves only once stages two and three agree
  generate
    for (genvar b = 0; b < LINES; b++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          clean_r[b] <= 1'b1;
        end else if (hold_r[b] == last_r[b]) begin
          clean_r[b] <= last_r[b];
        end
      end
    end
  endgenerate

  assign sif.clean = clean_r;

endmodule : spdio_sync

`default_nettype wire

/* File: spdio_top.sv */
// spdio_top: per-port direction, polarity, reference selection and data of 64 channels
// assumes: plain register port, read data one cycle after the read strobe;
// channels are open drain, pulled up outside to the selected reference
//
// Operation
// RL1 - each port holds direction and polarity; reset gives input, normal
// RL2 - port data access needs a selected reference; reset selects none, lines float
// RL3 - references offered: 3.3 V, 5 V, 12 V, 24 V or external supply
// RL4 - ttl emulation pulls to 5 V, low-voltage emulation to 3.3 V
// RL5 - data write drives an output port; ignored on an input port
// RL6 - data read returns present pin state, whoever drives it
// RL7 - far side applies no voltage to output ports; inputs between zero and reference
// RL8 - far side keeps lines free until and while reference is configured
// RL9 - emulation references only with output direction; input refused
// RL10 - card reset sets every output data register to all ones
// RL11 - direction change under emulation sets that port's data to all ones
// RL12 - finished reference configuration sets only that port's data to all ones
// RL13 - output data not kept over a direction change; drives all ones after
// RL14 - polarity applies to both directions
// RL15 - polarity change flips driven lines at once; later writes inverted too
// RL16 - read-back inverted when polarity reversed, unchanged otherwise
// RL17 - input ports release channels to a weak pull-up to their reference
// RL18 - a one turns the open-drain transistor off, a zero pulls low
// RL19 - 64 channels grouped as eight ports of eight channels
`default_nettype none

module spdio_top
  import spdio_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // channel pins, open drain
  input wire logic [LINES-1:0] chan_in,
  output logic [LINES-1:0] chan_out,
  output logic [LINES-1:0] chan_oe_n,
  // reference switches per port
  output logic [PORTS*SRC_W-1:0] vref_src_sel,
  output logic [PORTS-1:0] weak_pullup_en,
  output logic [PORTS-1:0] strong_pullup_en
);

  ////////////////////////////////////////////////////////////////////////////
  // decoding helpers

  // true for the two emulation references
  function automatic logic is_emul(input logic [VSEL_W-1:0] v);
    is_emul = (v == VSEL_TTL) || (v == VSEL_LOW_VOLTAGE_EMULATION);
  endfunction

  // one-hot source switch; none opens every switch
  function automatic logic [SRC_W-1:0] src_onehot(input logic [VSEL_W-1:0] v);
    logic [SRC_W:0] full;
    full = '0;
    full[v] = 1'b1;
    src_onehot = full[SRC_W:1];
  endfunction

  // register hit for port p inside a block of eight words
  function automatic logic port_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] base,
                                    input int p);
    logic [ADDR_W-1:0] off;
    off = ADDR_W'(p * 4);
    port_hit = (a == base + off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // per-port state

  logic [PORTS-1:0] dir_r;
  logic [PORTS-1:0] pol_r;
  logic [VSEL_W-1:0] vsel_r [PORTS];
  logic [CHANS-1:0] data_r [PORTS];

  // write and read decode results per port
  logic [PORTS-1:0] cfg_wr;
  logic [PORTS-1:0] cfg_ok;
  logic [PORTS-1:0] cfg_refused;
  logic [PORTS-1:0] data_wr;
  logic [PORTS-1:0] data_gated;
  logic [PORTS-1:0] rd_gated;
  logic [PORTS-1:0] volt_ok;

  // incoming config fields
  logic new_dir;
  logic new_pol;
  logic [VSEL_W-1:0] new_vsel;

  assign new_dir = reg_wdata[CFG_DIR_BIT];
  assign new_pol = reg_wdata[CFG_POL_BIT];
  assign new_vsel = reg_wdata[CFG_VSEL_LSB +: VSEL_W];

  // settled pin levels
  spdio_sync_if sync_bus ();
  logic [LINES-1:0] pins_clean;

  assign sync_bus.raw = chan_in;
  assign pins_clean = sync_bus.clean;

  spdio_sync u_sync (
    .clk (clk),
    .rst_n (rst_n),
    .sif (sync_bus.sink)
  );

  ////////////////////////////////////////////////////////////////////////////
  // per-port config and data registers

  generate
    for (genvar p = 0; p < PORTS; p++) begin : g_port
      logic dir_change;
      logic vsel_change;

      // ports 0..7 own eight channels each [RL19]
      assign volt_ok[p] = (vsel_r[p] != VSEL_NONE); // [RL2]
      assign cfg_wr[p] = reg_wr && port_hit(reg_addr, CFG_BASE, p);
      // input direction with an emulation reference is refused [RL9]
      assign cfg_ok[p] = !(new_dir == DIR_IN && is_emul(new_vsel));
      assign cfg_refused[p] = cfg_wr[p] && !cfg_ok[p];
      assign data_wr[p] = reg_wr && port_hit(reg_addr, DATA_BASE, p);
      assign data_gated[p] = data_wr[p] && !volt_ok[p]; // [RL2]
      assign rd_gated[p] = reg_rd && port_hit(reg_addr, DATA_BASE, p) && !volt_ok[p];
      assign dir_change = cfg_wr[p] && cfg_ok[p] && (new_dir != dir_r[p]);
      assign vsel_change = cfg_wr[p] && cfg_ok[p] && (new_vsel != vsel_r[p]);

      // direction and polarity, input and normal after reset [RL1]
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          dir_r[p] <= DIR_RST;
          pol_r[p] <= POL_RST;
        end else if (cfg_wr[p] && cfg_ok[p]) begin
          dir_r[p] <= new_dir;
          pol_r[p] <= new_pol; // [RL14]
        end
      end

      // reference choice, none after reset [RL2] [RL3] [RL4]
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          vsel_r[p] <= VSEL_NONE;
        end else if (cfg_wr[p] && cfg_ok[p]) begin
          vsel_r[p] <= new_vsel;
        end
      end

      // output data: all ones on reset and on a reference or direction change
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          data_r[p] <= DATA_RST; // [RL10]
        end else if (vsel_change) begin
          data_r[p] <= DATA_RST; // [RL12]
        end else if (dir_change && is_emul(vsel_r[p])) begin
          data_r[p] <= DATA_RST; // [RL11]
        end else if (dir_change) begin
          data_r[p] <= DATA_RST; // [RL13]
        end else if (data_wr[p] && volt_ok[p] && dir_r[p] == DIR_OUT) begin
          data_r[p] <= reg_wdata[CHANS-1:0]; // [RL5]
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // sticky status: refused config and gated data access

  logic refuse_r;
  logic gated_r;
  logic stat_clr;

  assign stat_clr = reg_wr && (reg_addr == STAT_ADDR);

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refuse_r <= 1'b0;
      gated_r <= 1'b0;
    end else begin
      refuse_r <= (refuse_r && !(stat_clr && reg_wdata[STAT_REFUSE_BIT]))
                  || (|cfg_refused); // [RL9]
      gated_r <= (gated_r && !(stat_clr && reg_wdata[STAT_GATED_BIT]))
                 || (|data_gated) || (|rd_gated); // [RL2]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path: answer in the cycle after the strobe only

  logic [DATA_W-1:0] rd_val;

  always_comb begin
    rd_val = '0;
    for (int p = 0; p < PORTS; p++) begin
      if (port_hit(reg_addr, CFG_BASE, p)) begin
        rd_val[CFG_DIR_BIT] = dir_r[p];
        rd_val[CFG_POL_BIT] = pol_r[p];
        rd_val[CFG_VSEL_LSB +: VSEL_W] = vsel_r[p];
      end
      if (port_hit(reg_addr, DATA_BASE, p) && volt_ok[p]) begin
        // pin state, inverted under reversed polarity [RL6] [RL16]
        rd_val[CHANS-1:0] = pins_clean[p*CHANS +: CHANS] ^ {CHANS{pol_r[p]}};
      end
    end
    if (reg_addr == STAT_ADDR) begin
      rd_val[STAT_REFUSE_BIT] = refuse_r;
      rd_val[STAT_GATED_BIT] = gated_r;
      rd_val[STAT_VOK_LSB +: PORTS] = volt_ok;
    end
  end

  // unmapped addresses read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rd_val;
    end else begin
      reg_rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel drivers, registered

  logic [LINES-1:0] oe_n_nxt;
  logic [PORTS*SRC_W-1:0] src_nxt;
  logic [PORTS-1:0] weak_nxt;
  logic [PORTS-1:0] strong_nxt;

  always_comb begin
    for (int p = 0; p < PORTS; p++) begin
      for (int c = 0; c < CHANS; c++) begin
        // zero pulls low, one releases; polarity flips at once [RL18] [RL15]
        oe_n_nxt[p*CHANS + c] = !(dir_r[p] == DIR_OUT && volt_ok[p]
                                  && (data_r[p][c] ^ pol_r[p]) == 1'b0);
      end
      src_nxt[p*SRC_W +: SRC_W] = src_onehot(vsel_r[p]); // [RL3] [RL4]
      weak_nxt[p] = volt_ok[p] && !is_emul(vsel_r[p]); // [RL17]
      strong_nxt[p] = is_emul(vsel_r[p]) && dir_r[p] == DIR_OUT; // [RL4] [RL9]
    end
  end

  // every line released and every switch open from reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_oe_n <= LINE_IDLE;
      chan_out <= '0;
      vref_src_sel <= '0;
      weak_pullup_en <= '0;
      strong_pullup_en <= '0;
    end else begin
      chan_oe_n <= oe_n_nxt;
      chan_out <= '0;
      vref_src_sel <= src_nxt;
      weak_pullup_en <= weak_nxt;
      strong_pullup_en <= strong_nxt;
    end
  end

endmodule : spdio_top

`default_nettype wire

/* File: spdio_checker.sv */
// spdio_checker: port assertions for spdio_top
// assumes: one clk domain, bound to every spdio_top below
`default_nettype none

module spdio_checker
  import spdio_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  // pins and switches
  input wire logic [LINES-1:0] chan_out,
  input wire logic [LINES-1:0] chan_oe_n,
  input wire logic [PORTS*SRC_W-1:0] vref_src_sel,
  input wire logic [PORTS-1:0] weak_pullup_en,
  input wire logic [PORTS-1:0] strong_pullup_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // addressed port and its switches
  logic [2:0] pa;
  logic cfg_a;
  logic dat_a;
  logic [SRC_W-1:0] src;
  assign pa = reg_addr[4:2];
  assign cfg_a = reg_addr[7:5] == 3'h0 && reg_addr[1:0] == 2'h0;
  assign dat_a = reg_addr[7:5] == 3'h1 && reg_addr[1:0] == 2'h0;
  assign src = vref_src_sel[pa*SRC_W +: SRC_W];
  ////////////////////////////////////////
  property p_idle;
    !reg_rd |=> reg_rdata == '0;
  endproperty
  a_idle: assert property (p_idle) else $error("read data without read");
  property p_gated;
    reg_rd && dat_a && src == '0 |=> reg_rdata == '0;
  endproperty
  a_gated: assert property (p_gated) else $error("ungated data read");
  property p_fresh;
    logic [2:0] p;
    logic [7:0] e;
    (reg_wr && cfg_a && src == '0 && reg_wdata[6:4] != 3'h0 &&
     (reg_wdata[0] || !(reg_wdata[6] && reg_wdata[5])), p = pa,
     e = reg_wdata[0] ? {8{!reg_wdata[1]}} : 8'hff) |-> ##2 chan_oe_n[p*CHANS +: CHANS] == e;
  endproperty
  a_fresh: assert property (p_fresh) else $error("data not all ones");
  property p_reset;
    $rose(rst_n) |-> chan_oe_n == '1 && vref_src_sel == '0 && reg_rdata == '0;
  endproperty
  a_reset: assert property (p_reset) else $error("bad state after reset");
  property p_open;
    chan_out == '0;
  endproperty
  a_open: assert property (p_open) else $error("line driven high");
  // per-port switch and release checks
  for (genvar g = 0; g < PORTS; g++) begin : g_port
    logic [SRC_W-1:0] s;
    assign s = vref_src_sel[g*SRC_W +: SRC_W];
    property p_noref;
      s == '0 |-> chan_oe_n[g*CHANS +: CHANS] == 8'hff;
    endproperty
    a_noref: assert property (p_noref) else $error("pulled without reference");
    property p_strong;
      strong_pullup_en[g] |-> (s[5] || s[6]) && !weak_pullup_en[g];
    endproperty
    a_strong: assert property (p_strong) else $error("strong pull-up");
    property p_sel;
      $onehot0(s) && (weak_pullup_en[g] == (s[4:0] != 5'h0));
    endproperty
    a_sel: assert property (p_sel) else $error("bad reference switch");
  end
  // main scenarios reached
  c_fresh: cover property (reg_wr && cfg_a && src == '0);
  c_gated: cover property (reg_rd && dat_a && src == '0);
  c_strong: cover property (|strong_pullup_en);
endmodule // spdio_checker

bind spdio_top spdio_checker chk_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .chan_out(chan_out), .chan_oe_n(chan_oe_n), .vref_src_sel(vref_src_sel),
  .weak_pullup_en(weak_pullup_en), .strong_pullup_en(strong_pullup_en));

`default_nettype wire

/* File: spdio_uut_model.sv */
// spdio_uut_model: unit under test wired to the 64 channels
// assumes: bench enables driving only on referenced input ports
`default_nettype none

module spdio_uut_model
  import spdio_pkg::*;
(
  // clock
  input wire logic clk,
  // card side
  input wire logic [LINES-1:0] chan_oe_n,
  input wire logic [PORTS*SRC_W-1:0] vref_src_sel,
  // unit drive
  input wire logic [LINES-1:0] drv,
  input wire logic [PORTS-1:0] drv_en,
  // line levels
  output logic [LINES-1:0] chan_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip_r = 1'b0;
  // unreferenced lines float: changing pattern
  always @(posedge clk) flip_r <= ~flip_r;
  // wired level: pulled up unless card or unit pulls low
  always_comb begin
    for (int i = 0; i < LINES; i++) begin
      if (vref_src_sel[i/CHANS*SRC_W +: SRC_W] == '0) chan_in[i] = flip_r ^ i[0];
      else chan_in[i] = chan_oe_n[i] & (drv_en[i/CHANS] ? drv[i] : 1'b1);
    end
  end
endmodule // spdio_uut_model

`default_nettype wire

/* File: test_static_port_digital_io.sv */
// test_static_port_digital_io: self-checking bench for spdio_top
// assumes: spdio_uut_model on the channels, checker bound
`default_nettype none

module test_static_port_digital_io;
  import spdio_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, reg_wr, reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, d;
  logic [LINES-1:0] chan_in, chan_out, chan_oe_n, drv;
  logic [PORTS*SRC_W-1:0] vref_src_sel;
  logic [PORTS-1:0] weak_pullup_en, strong_pullup_en, drv_en;
  logic dir [PORTS];
  logic pol [PORTS];
  logic [2:0] vs [PORTS];
  logic [7:0] dat [PORTS];
  int err_count, total_checks, k;
  ////////////////////////////////////////
  spdio_top dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chan_in(chan_in),
    .chan_out(chan_out), .chan_oe_n(chan_oe_n), .vref_src_sel(vref_src_sel),
    .weak_pullup_en(weak_pullup_en), .strong_pullup_en(strong_pullup_en));
  spdio_uut_model uut_u (.clk(clk), .chan_oe_n(chan_oe_n), .vref_src_sel(vref_src_sel),
    .drv(drv), .drv_en(drv_en), .chan_in(chan_in));
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////
  // expected and observed port lines, zero pulls low
  function automatic logic [7:0] eo(int p);
    return dir[p] ? dat[p] ^ {8{pol[p]}} : 8'hff;
  endfunction
  function automatic logic [7:0] oe(int p);
    return chan_oe_n[p*CHANS +: CHANS];
  endfunction
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    total_checks++;
    if (g !== e) begin
      $display("unexpected at %0t: %h not %h", $time, g, e);
      err_count++;
    end
  endtask
  task automatic summarize();
    if (err_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cfg(input int p);
    wr(8'(p*4), {25'h0, vs[p], 2'b0, pol[p], dir[p]});
    settle(2);
  endtask
  ////////////////////////////////////////
  // watchdog
  initial begin
    #500us;
    err_count++;
    summarize();
  end
  // main sequence
  initial begin
    void'($urandom(61847));
    {rst_n, reg_wr, reg_rd, drv_en} = '0;
    {reg_addr, reg_wdata, drv} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (k = 0; k < PORTS; k++) begin
      rd(8'(k*4));
      chk(d, 0);
      rd(DATA_BASE + 8'(k*4));
      chk(d, 0);
    end
    chk(chan_oe_n, LINE_IDLE);
    rd(STAT_ADDR);
    chk(d[1], 1'b1);
    rd(8'h80);
    chk(d, 0);
    wr(STAT_ADDR, 32'h3);
    wr(8'h1c, 32'h60);
    rd(STAT_ADDR);
    chk(d[0], 1'b1);
    chk(vref_src_sel[7*SRC_W +: SRC_W], 0);
    // every reference at least once, 3.3 V twice, all ports output
    for (k = 0; k < PORTS; k++) begin
      vs[k] = k < 7 ? 3'(k + 1) : 3'h1;
      dir[k] = 1'b1;
      pol[k] = 1'($urandom);
      dat[k] = 8'hff;
      cfg(k);
      chk(oe(k), eo(k));
      chk(vref_src_sel[k*SRC_W +: SRC_W], 7'h1 << (vs[k] - 1));
      chk(strong_pullup_en[k], vs[k] > 5);
      chk(weak_pullup_en[k], vs[k] < 6);
    end
    // every port now has a reference; open drain never drives high
    rd(STAT_ADDR);
    chk(d[15:8], 8'hff);
    chk(chan_out, 0);
    // random data with zero and all ones first
    for (int i = 0; i < 24; i++) begin
      k = $urandom % 8;
      dat[k] = i < 2 ? {8{i[0]}} : 8'($urandom);
      wr(DATA_BASE + 8'(k*4), {24'h0, dat[k]});
      settle(2);
      chk(oe(k), eo(k));
      settle(6);
      rd(DATA_BASE + 8'(k*4));
      chk(d, {24'h0, dat[k]});
    end
    // polarity flip keeps data
    pol[0] = !pol[0];
    cfg(0);
    chk(oe(0), eo(0));
    // port 1 to input, driven by the unit, writes ignored
    dat[1] = 8'haa;
    wr(DATA_BASE + 8'h04, 32'haa);
    dir[1] = 1'b0;
    cfg(1);
    chk(oe(1), 8'hff);
    drv[15:8] = 8'($urandom);
    drv_en[1] = 1'b1;
    wr(DATA_BASE + 8'h04, 32'h0);
    settle(8);
    chk(oe(1), 8'hff);
    rd(DATA_BASE + 8'h04);
    chk(d, {24'h0, drv[15:8] ^ {8{pol[1]}}});
    drv_en[1] = 1'b0;
    dir[1] = 1'b1;
    dat[1] = 8'hff;
    cfg(1);
    chk(oe(1), eo(1));
    // emulation port refuses input and flags it
    wr(STAT_ADDR, 32'h1);
    dir[5] = 1'b0;
    cfg(5);
    dir[5] = 1'b1;
    chk(oe(5), eo(5));
    rd(STAT_ADDR);
    chk(d[0], 1'b1);
    // second reset, driven on the clock edge
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    settle(1);
    chk(chan_oe_n, LINE_IDLE);
    chk(vref_src_sel, 0);
    rd(8'h00);
    chk(d, 0);
    summarize();
  end
endmodule // test_static_port_digital_io

`default_nettype wire
